/* File: include/sfm_consts.vh */
// register offsets, field positions and reset values of the supply fault monitor
`ifndef SFM_CONSTS_VH
`define SFM_CONSTS_VH

// register word offsets
`define SFM_OFS_RESULT0    5'h00
`define SFM_OFS_OVLIM0     5'h06
`define SFM_OFS_UVLIM0     5'h0C
`define SFM_OFS_MON_SEL    5'h12
`define SFM_OFS_FAULT_EN   5'h13
`define SFM_OFS_FAULT_INST 5'h14
`define SFM_OFS_FAULT_LAT  5'h15
`define SFM_OFS_SUMMARY    5'h16
`define SFM_OFS_PIN_CTRL   5'h17

// fault vector layout: [5:0] under, [11:6] over, [12] trim 0, [13] trim 1
`define SFM_FLT_UV_LSB     0
`define SFM_FLT_OV_LSB     6
`define SFM_FLT_DAC0       12
`define SFM_FLT_DAC1       13

// pin control fields
`define SFM_PC_CFG0_LSB    0
`define SFM_PC_CFG1_LSB    2
`define SFM_PC_VAL0        4
`define SFM_PC_VAL1        5
`define SFM_PC_ALERT_MASKN 6
`define SFM_PC_OVERRIDE    7
`define SFM_PC_ALERT_LVL   8

// result register new-data flag
`define SFM_RES_NEW        15

// pin function codes
`define SFM_FN_RELEASE     2'h0
`define SFM_FN_FLAG        2'h1
`define SFM_FN_OD_OUT      2'h2
`define SFM_FN_INPUT       2'h3

// limit codes that switch a comparison off, and trim codes that raise a trim fault
`define SFM_OV_INHIBIT     15'h3FFF
`define SFM_UV_INHIBIT     15'h4000
`define SFM_DAC_LOW        8'h00
`define SFM_DAC_HIGH       8'hFF

// reset values
`define SFM_RST_MON_SEL    6'h00
`define SFM_RST_FAULT_EN   14'h0000
`define SFM_RST_ALERT_MASKN 1'h1

`endif

/* File: verilog/sfm_supply_fault_monitor.v */
// supply fault monitor: limit compare, fault latches, alert and general pin logic
// Contract
// - over fault set when result above upper limit, cleared otherwise, per conversion.
// - upper limit 14'h3fff disables that channel's over fault.
// - under fault set when result below lower limit, cleared otherwise, per conversion.
// - lower limit 14'h4000 disables that channel's under fault.
// - after a pass, trim code 'h00 or 'hff sets that channel's trim fault.
// - six under, six over, two trim faults readable in one status read.
// - supply ok flag high with no voltage fault; on pin 0 and its value bit.
// - trim limit flag high with any trim fault; on pin 1 and its value bit.
// - results and limits are 15-bit two's complement, bit 14 is sign.
// - voltage faults of a channel refresh only while its monitor bit is high.
// - with latch enable high, latched bit sets with the instantaneous fault.
// - latched bit stays set after instantaneous fault clears until cleared.
// - writing a latch enable bit low clears its latched bit at once.
// - reading latched register returns bits then clears all fourteen.
// - summary read reports any latched fault without clearing them.
// - with alert mask low, alert pulled low while any latched fault set; level readable.
// - function 2'b10 makes pin an open-drain output of its value bit.
// - function 2'b11 makes pin an input read back through its value bit.
// - at reset both pins are outputs driving the inverse of the strap level.
// - override bit stops conversions and lets bus writes load result registers.
// - A-channel conversions get priority while either is in fast servo.
// - conversion sets a result's new-data bit; reading the result clears it.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "sfm_consts.vh"

module sfm_supply_fault_monitor #(
  parameter NCH = 6                        // voltage channels: 0 vdd,1 v12,2 ch0a,3 ch0b,4 ch1a,5 ch1b
) (
  input  wire        sys_clk,              // system clock, 50 MHz
  input  wire        reset_n,              // asynchronous reset, active low
  input  wire [4:0]  reg_addr,             // register word offset
  input  wire [15:0] reg_wdata,            // write data
  input  wire        reg_wr,               // write strobe
  input  wire        reg_rd,               // read strobe
  output reg  [15:0] reg_rdata,            // read data, cycle after reg_rd
  input  wire        conv_valid,           // one-cycle pulse: conversion done
  input  wire [2:0]  conv_chan,            // channel of conv_data
  input  wire [14:0] conv_data,            // signed conversion result
  input  wire        pass_done,            // one-cycle pulse: all enabled conversions done
  input  wire [7:0]  trim_code0,           // trim dac code, channel 0
  input  wire [7:0]  trim_code1,           // trim dac code, channel 1
  input  wire        fast_servo0,          // channel 0 in fast servo phase
  input  wire        fast_servo1,          // channel 1 in fast servo phase
  output wire        conv_run,             // sequencer may convert
  output wire [5:0]  conv_select,          // channels the sequencer should convert
  output wire        conv_prio_a,          // sequencer must favour the A channels
  input  wire        strap_level_pin,      // pin strap, sampled after reset
  input  wire        gpin0_in,             // general pin 0 level
  output wire        gpin0_out,            // general pin 0 drive value
  output wire        gpin0_oe,             // general pin 0 pulls low
  input  wire        gpin1_in,             // general pin 1 level
  output wire        gpin1_out,            // general pin 1 drive value
  output wire        gpin1_oe,             // general pin 1 pulls low
  input  wire        alert_in,             // alert pin level
  output wire        alert_out,            // alert drive value
  output wire        alert_oe              // alert pulls low
);

  // limit and result storage, limits deliberately without reset
  reg  [14:0] result_mem [0:NCH-1];
  reg  [14:0] ovlim_mem  [0:NCH-1];
  reg  [14:0] uvlim_mem  [0:NCH-1];
  reg  [NCH-1:0] new_reg;
  reg  [NCH-1:0] mon_sel_reg;
  reg  [13:0] fault_en_reg;
  reg  [13:0] inst_reg;
  reg  [13:0] inst_next;
  reg  [13:0] lat_reg;
  reg  [13:0] lat_next;
  reg  [13:0] set_evt;
  reg  [1:0]  cfg0_reg;
  reg  [1:0]  cfg1_reg;
  reg         val0_reg;
  reg         val1_reg;
  reg         alert_maskn_reg;
  reg         override_reg;
  reg         strap_done_reg;
  reg  [1:0]  strap_sync_reg;
  reg  [1:0]  strap_fill_reg;
  reg  [1:0]  g0_sync_reg;
  reg  [1:0]  g1_sync_reg;
  reg  [1:0]  al_sync_reg;
  reg  [15:0] rdata_next;
  reg  [14:0] cmp_val;
  reg  [2:0]  cmp_ch;
  reg         cmp_go;
  genvar      ch;

  wire        supply_ok_flag;
  wire        trim_limit_flag;
  wire        any_latched;
  wire        g0_val;
  wire        g1_val;
  wire [NCH-1:0] new_next;

  // index code for an address outside the register group
  localparam [2:0] NO_IDX = NCH;

  // address is a result, limit register: returns the index or NCH if not in range
  function [2:0] sfm_index;
    input [4:0] a;
    input [4:0] base;
    begin
      // a group spans fewer than eight words, so three low bits subtract cleanly
      if (a >= base && a < base + NCH[4:0])
        sfm_index = a[2:0] - base[2:0];
      else
        sfm_index = NO_IDX;
    end
  endfunction

  wire [2:0] res_idx = sfm_index(reg_addr, `SFM_OFS_RESULT0);
  wire [2:0] ov_idx  = sfm_index(reg_addr, `SFM_OFS_OVLIM0);
  wire [2:0] uv_idx  = sfm_index(reg_addr, `SFM_OFS_UVLIM0);

  // strap synchroniser; the fill bits mark when stage two holds a real sample
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_sync_reg <= 2'h0;
      strap_fill_reg <= 2'h0;
    end else begin
      strap_sync_reg <= {strap_sync_reg[0], strap_level_pin};
      strap_fill_reg <= {strap_fill_reg[0], 1'b1};
    end
  end

  // pin level synchronisers; pins idle high behind their pull-ups
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      g0_sync_reg    <= 2'h3;
      g1_sync_reg    <= 2'h3;
      al_sync_reg    <= 2'h3;
    end else begin
      g0_sync_reg    <= {g0_sync_reg[0], gpin0_in};
      g1_sync_reg    <= {g1_sync_reg[0], gpin1_in};
      al_sync_reg    <= {al_sync_reg[0], alert_in};
    end
  end

  // sequencer handshake: the bus owns the result registers while override is set
  assign conv_run    = ~override_reg;
  assign conv_select = mon_sel_reg;
  assign conv_prio_a = fast_servo0 | fast_servo1;

  // pick the value to compare: conversion, or a bus write during override
  always @* begin
    cmp_go  = 1'b0;
    cmp_ch  = conv_chan;
    cmp_val = conv_data;
    if (override_reg) begin
      if (reg_wr && res_idx != NCH[2:0]) begin
        cmp_go  = 1'b1;
        cmp_ch  = res_idx;
        cmp_val = reg_wdata[14:0];
      end
    end else if (conv_valid && conv_chan < NCH[2:0]) begin
      cmp_go = 1'b1;
    end
  end

  // instantaneous faults and the set events that feed the latches
  always @* begin
    inst_next = inst_reg;
    set_evt   = 14'h0000;
    if (cmp_go && mon_sel_reg[cmp_ch]) begin
      // signed compare so negative results order correctly
      inst_next[`SFM_FLT_OV_LSB + cmp_ch] =
        ($signed(cmp_val) > $signed(ovlim_mem[cmp_ch])) &&
        (ovlim_mem[cmp_ch] != `SFM_OV_INHIBIT);
      inst_next[`SFM_FLT_UV_LSB + cmp_ch] =
        ($signed(cmp_val) < $signed(uvlim_mem[cmp_ch])) &&
        (uvlim_mem[cmp_ch] != `SFM_UV_INHIBIT);
      set_evt[`SFM_FLT_OV_LSB + cmp_ch] = inst_next[`SFM_FLT_OV_LSB + cmp_ch];
      set_evt[`SFM_FLT_UV_LSB + cmp_ch] = inst_next[`SFM_FLT_UV_LSB + cmp_ch];
    end
    if (pass_done) begin
      inst_next[`SFM_FLT_DAC0] = (trim_code0 == `SFM_DAC_LOW) || (trim_code0 == `SFM_DAC_HIGH);
      inst_next[`SFM_FLT_DAC1] = (trim_code1 == `SFM_DAC_LOW) || (trim_code1 == `SFM_DAC_HIGH);
      set_evt[`SFM_FLT_DAC0]   = inst_next[`SFM_FLT_DAC0];
      set_evt[`SFM_FLT_DAC1]   = inst_next[`SFM_FLT_DAC1];
    end
  end

  // latched faults: a set in the clearing cycle wins over the clear
  always @* begin
    lat_next = lat_reg;
    if (reg_rd && reg_addr == `SFM_OFS_FAULT_LAT)
      lat_next = 14'h0000;
    if (reg_wr && reg_addr == `SFM_OFS_FAULT_EN)
      lat_next = lat_next & reg_wdata[13:0];
    else
      lat_next = lat_next & fault_en_reg;
    if (reg_wr && reg_addr == `SFM_OFS_FAULT_EN)
      lat_next = lat_next | (set_evt & reg_wdata[13:0]);
    else
      lat_next = lat_next | (set_evt & fault_en_reg);
  end

  // flags that the general pins can show
  assign supply_ok_flag  = ~|inst_reg[11:0];
  assign trim_limit_flag = inst_reg[`SFM_FLT_DAC0] | inst_reg[`SFM_FLT_DAC1];

  // any latched fault feeds both the alert and the summary read
  assign any_latched     = |lat_reg;

  // general pins are open drain: they never drive high
  assign gpin0_out = 1'b0;
  assign gpin1_out = 1'b0;

  // pin enables: enable means pulling low
  assign gpin0_oe  = (cfg0_reg == `SFM_FN_OD_OUT) ? ~val0_reg :
                     (cfg0_reg == `SFM_FN_FLAG) ? ~supply_ok_flag : 1'b0;
  assign gpin1_oe  = (cfg1_reg == `SFM_FN_OD_OUT) ? ~val1_reg :
                     (cfg1_reg == `SFM_FN_FLAG) ? ~trim_limit_flag : 1'b0;

  // alert pulls low while unmasked and any fault is latched
  assign alert_out = 1'b0;
  assign alert_oe  = ~alert_maskn_reg & any_latched;

  // pin 0 value bit: input level, supply ok flag or written value
  assign g0_val = (cfg0_reg == `SFM_FN_INPUT) ? g0_sync_reg[1] :
                  (cfg0_reg == `SFM_FN_FLAG) ? supply_ok_flag : val0_reg;

  // pin 1 value bit: input level, trim limit flag or written value
  assign g1_val = (cfg1_reg == `SFM_FN_INPUT) ? g1_sync_reg[1] :
                  (cfg1_reg == `SFM_FN_FLAG) ? trim_limit_flag : val1_reg;

  // fault status registers
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      inst_reg <= 14'h0000;
      lat_reg  <= 14'h0000;
    end else begin
      inst_reg <= inst_next;
      lat_reg  <= lat_next;
    end
  end

  // control registers; pins stay released until the strap has really been seen
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mon_sel_reg     <= `SFM_RST_MON_SEL;
      fault_en_reg    <= `SFM_RST_FAULT_EN;
      new_reg         <= {NCH{1'b0}};
      cfg0_reg        <= `SFM_FN_OD_OUT;
      cfg1_reg        <= `SFM_FN_OD_OUT;
      val0_reg        <= 1'b1;
      val1_reg        <= 1'b1;
      alert_maskn_reg <= `SFM_RST_ALERT_MASKN;
      override_reg    <= 1'b0;
      strap_done_reg  <= 1'b0;
    end else begin
      new_reg <= new_next;
      // strap level reaches the pins once the synchroniser has filled
      if (!strap_done_reg && strap_fill_reg[1]) begin
        strap_done_reg <= 1'b1;
        val0_reg       <= ~strap_sync_reg[1];
        val1_reg       <= ~strap_sync_reg[1];
      end
      if (reg_wr) begin
        if (reg_addr == `SFM_OFS_MON_SEL) begin
          mon_sel_reg <= reg_wdata[NCH-1:0];
        end else if (reg_addr == `SFM_OFS_FAULT_EN) begin
          fault_en_reg <= reg_wdata[13:0];
        end else if (reg_addr == `SFM_OFS_PIN_CTRL) begin
          cfg0_reg        <= reg_wdata[`SFM_PC_CFG0_LSB +: 2];
          cfg1_reg        <= reg_wdata[`SFM_PC_CFG1_LSB +: 2];
          val0_reg        <= reg_wdata[`SFM_PC_VAL0];
          val1_reg        <= reg_wdata[`SFM_PC_VAL1];
          alert_maskn_reg <= reg_wdata[`SFM_PC_ALERT_MASKN];
          override_reg    <= reg_wdata[`SFM_PC_OVERRIDE];
        end
      end
    end
  end

  // new-data flags: a conversion in the read cycle keeps its flag
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_new
      localparam [2:0] CH_IDX = ch;
      assign new_next[ch] = (cmp_go && cmp_ch == CH_IDX) ? 1'b1 :
                            (reg_rd && res_idx == CH_IDX) ? 1'b0 : new_reg[ch];
    end
  endgenerate

  // result storage: a conversion, or a bus write while override holds the bus
  always @(posedge sys_clk) begin
    if (cmp_go)
      result_mem[cmp_ch] <= cmp_val;
  end

  // limit storage; limits carry no reset, software must load them first
  always @(posedge sys_clk) begin
    if (reg_wr && ov_idx != NCH[2:0])
      ovlim_mem[ov_idx] <= reg_wdata[14:0];
    if (reg_wr && uv_idx != NCH[2:0])
      uvlim_mem[uv_idx] <= reg_wdata[14:0];
  end

  // read mux; unmapped offsets read as zero
  always @* begin
    rdata_next = 16'h0000;
    if (res_idx != NCH[2:0]) begin
      rdata_next = {new_reg[res_idx], result_mem[res_idx]};
    end else if (ov_idx != NCH[2:0]) begin
      rdata_next = {1'b0, ovlim_mem[ov_idx]};
    end else if (uv_idx != NCH[2:0]) begin
      rdata_next = {1'b0, uvlim_mem[uv_idx]};
    end else if (reg_addr == `SFM_OFS_MON_SEL) begin
      rdata_next[NCH-1:0] = mon_sel_reg;
    end else if (reg_addr == `SFM_OFS_FAULT_EN) begin
      rdata_next[13:0] = fault_en_reg;
    end else if (reg_addr == `SFM_OFS_FAULT_INST) begin
      rdata_next[13:0] = inst_reg;
    end else if (reg_addr == `SFM_OFS_FAULT_LAT) begin
      rdata_next[13:0] = lat_reg;
    end else if (reg_addr == `SFM_OFS_SUMMARY) begin
      rdata_next[0] = any_latched;
    end else if (reg_addr == `SFM_OFS_PIN_CTRL) begin
      rdata_next[`SFM_PC_CFG0_LSB +: 2] = cfg0_reg;
      rdata_next[`SFM_PC_CFG1_LSB +: 2] = cfg1_reg;
      rdata_next[`SFM_PC_VAL0]          = g0_val;
      rdata_next[`SFM_PC_VAL1]          = g1_val;
      rdata_next[`SFM_PC_ALERT_MASKN]   = alert_maskn_reg;
      rdata_next[`SFM_PC_OVERRIDE]      = override_reg;
      rdata_next[`SFM_PC_ALERT_LVL]     = al_sync_reg[1];
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 16'h0000;
  end

endmodule

/* File: sim/sfm_pin_pullups.sv */
// open-drain pull-ups and outside drivers around the fault monitor pins
`timescale 1ns/100ps
module sfm_pin_pullups (
  input  wire gpin0_oe,  // monitor pulls pin 0 low
  input  wire gpin1_oe,  // monitor pulls pin 1 low
  input  wire alert_oe,  // monitor pulls alert low
  input  wire ext_low0,  // outside part pulls pin 0 low
  input  wire ext_low1,  // outside part pulls pin 1 low
  output wire gpin0_in,  // resolved pin 0 level
  output wire gpin1_in,  // resolved pin 1 level
  output wire alert_in   // resolved alert level
);
  // wired-and with pull-ups: a released line reads high, never a stale driven value
  assign gpin0_in = ~(gpin0_oe | ext_low0);
  assign gpin1_in = ~(gpin1_oe | ext_low1);
  assign alert_in = ~alert_oe;
endmodule

/* File: sim/sfm_supply_fault_monitor_monitor.sv */
// port assertions for the supply fault monitor
`timescale 1ns/100ps
module sfm_supply_fault_monitor_monitor (
  input wire        sys_clk,     // clock
  input wire        reset_n,     // reset, active low
  input wire [4:0]  reg_addr,    // offset
  input wire [15:0] reg_wdata,   // write data
  input wire        reg_wr,      // write strobe
  input wire        reg_rd,      // read strobe
  input wire [15:0] reg_rdata,   // read data
  input wire        conv_valid,  // conversion pulse
  input wire        pass_done,   // pass end pulse
  input wire        fast_servo0, // servo phase 0
  input wire        fast_servo1, // servo phase 1
  input wire        conv_run,    // conversions allowed
  input wire [5:0]  conv_select, // monitor bits
  input wire        conv_prio_a, // a-channel priority
  input wire        gpin0_out,   // pin 0 value
  input wire        gpin0_oe,    // pin 0 pull
  input wire        gpin1_out,   // pin 1 value
  input wire        gpin1_oe,    // pin 1 pull
  input wire        alert_out,   // alert value
  input wire        alert_oe     // alert pull
);
  reg [15:0] wd_q;
  // last cycle's write data, kept so $past needs no part-select
  always @(posedge sys_clk) wd_q <= reg_wdata;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_prio_follow: assert property (conv_prio_a == (fast_servo0 | fast_servo1))
    else $error("priority does not follow servo phase");
  a_drive_low_only: assert property (!gpin0_out && !gpin1_out && !alert_out)
    else $error("open-drain pin drives high");
  a_od_pull_low: assert property (reg_wr && reg_addr == 5'h17 && reg_wdata[1:0] == 2'b10 && !reg_wdata[4]
    |=> gpin0_oe) else $error("pin 0 not pulled low");
  a_input_release: assert property (reg_wr && reg_addr == 5'h17 && reg_wdata[3:2] == 2'b11 |=> !gpin1_oe)
    else $error("input pin still driven");
  a_alert_masked: assert property (reg_wr && reg_addr == 5'h17 && reg_wdata[6] |=> !alert_oe)
    else $error("masked alert still pulled");
  a_override_run: assert property (reg_wr && reg_addr == 5'h17 && reg_wdata[7] |=> !conv_run)
    else $error("conversions run under override");
  a_monsel_load: assert property (reg_wr && reg_addr == 5'h12 |=> conv_select == wd_q[5:0])
    else $error("monitor select not loaded");
  a_readclr_lat: assert property ((reg_rd && reg_addr == 5'h15 && !conv_valid && !pass_done) ##1
    (reg_rd && reg_addr == 5'h15 && !conv_valid && !pass_done) |=> reg_rdata == 16'h0000)
    else $error("latched faults survive a read");
  a_summary_keep: assert property ((reg_rd && reg_addr == 5'h16 && !conv_valid && !pass_done) ##1
    (reg_rd && reg_addr == 5'h16 && !conv_valid && !pass_done) |=> $stable(reg_rdata))
    else $error("summary read changed latches");
  a_enclr_lat: assert property ((reg_wr && reg_addr == 5'h13 && reg_wdata == 16'h0000) ##1
    (reg_rd && reg_addr == 5'h15) |=> reg_rdata == 16'h0000) else $error("disable left latch set");
endmodule

bind sfm_supply_fault_monitor sfm_supply_fault_monitor_monitor i_sfm_supply_fault_monitor_monitor (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid), .pass_done(pass_done),
  .fast_servo0(fast_servo0), .fast_servo1(fast_servo1), .conv_run(conv_run), .conv_select(conv_select),
  .conv_prio_a(conv_prio_a), .gpin0_out(gpin0_out), .gpin0_oe(gpin0_oe), .gpin1_out(gpin1_out),
  .gpin1_oe(gpin1_oe), .alert_out(alert_out), .alert_oe(alert_oe));

/* File: sim/sfm_supply_fault_monitor_bench.sv */
// self-checking bench for the supply fault monitor
`timescale 1ns/100ps
module sfm_supply_fault_monitor_bench;
  reg         sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  reg         conv_valid = 1'b0, pass_done = 1'b0, fast_servo0 = 1'b0, fast_servo1 = 1'b0;
  reg         ext_low0 = 1'b0, ext_low1 = 1'b0, strap = 1'b0;
  reg  [4:0]  reg_addr = 5'h00;
  reg  [15:0] reg_wdata = 16'h0000;
  reg  [2:0]  conv_chan = 3'h0;
  reg  [14:0] conv_data = 15'h0000, d;
  reg  [7:0]  trim_code0 = 8'h80, trim_code1 = 8'h80;
  reg  [13:0] inst_e = 14'h0000, lat_e = 14'h0000;
  reg  [31:0] seed = 32'hEB89;
  reg  [15:0] expq[$];
  wire [15:0] reg_rdata;
  wire [5:0]  conv_select;
  wire        conv_run, conv_prio_a, gpin0_in, gpin0_out, gpin0_oe, gpin1_in, gpin1_out, gpin1_oe;
  wire        alert_in, alert_out, alert_oe;
  integer     n_mismatch = 0, checked = 0, i;

  sfm_supply_fault_monitor i_sfm_supply_fault_monitor (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid), .conv_chan(conv_chan),
    .conv_data(conv_data), .pass_done(pass_done), .trim_code0(trim_code0), .trim_code1(trim_code1),
    .fast_servo0(fast_servo0), .fast_servo1(fast_servo1), .conv_run(conv_run), .conv_select(conv_select),
    .conv_prio_a(conv_prio_a), .strap_level_pin(strap), .gpin0_in(gpin0_in), .gpin0_out(gpin0_out),
    .gpin0_oe(gpin0_oe), .gpin1_in(gpin1_in), .gpin1_out(gpin1_out), .gpin1_oe(gpin1_oe),
    .alert_in(alert_in), .alert_out(alert_out), .alert_oe(alert_oe));
  sfm_pin_pullups i_sfm_pin_pullups (.gpin0_oe(gpin0_oe), .gpin1_oe(gpin1_oe), .alert_oe(alert_oe),
    .ext_low0(ext_low0), .ext_low1(ext_low1), .gpin0_in(gpin0_in), .gpin1_in(gpin1_in), .alert_in(alert_in));

  always #10 sys_clk = ~sys_clk;

  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task chk(input [15:0] seen, input [15:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask

  // every bus task sets both strobes, so back-to-back calls never assign twice in one step
  task bus(input w, input r, input [4:0] a, input [15:0] dat);
    begin
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= dat;
      @(posedge sys_clk);
    end
  endtask
  task nop;
    bus(1'b0, 1'b0, 5'h00, 16'h0000);
  endtask
  task wr(input [4:0] a, input [15:0] dat);
    bus(1'b1, 1'b0, a, dat);
  endtask
  task rd(input [4:0] a, input [15:0] want);
    begin
      expq.push_back(want);
      bus(1'b0, 1'b1, a, 16'h0000);
    end
  endtask
  task cv(input v, input p, input [2:0] ch, input [14:0] dat);
    begin
      conv_valid <= v;
      pass_done <= p;
      conv_chan <= ch;
      conv_data <= dat;
      nop;
      conv_valid <= 1'b0;
      pass_done <= 1'b0;
      nop;
    end
  endtask

  // read data stand only in the cycle after the strobe: take the oldest note then
  always @(posedge sys_clk) begin
    if (rd_seen && expq.size() > 0)
      chk(reg_rdata, expq.pop_front());
    rd_seen <= reg_rd;
  end

  task results;
    begin
      if (n_mismatch == 0 && checked > 0 && expq.size() == 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // hang guard, far beyond the roughly 140 cycles the sequence needs
  initial begin
    #2000000;
    n_mismatch = n_mismatch + 1;
    results;
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) nop;
    #1 chk(gpin0_oe, 1'b0);
    chk(gpin1_oe, 1'b0);
    rd(5'h17, 16'h017A);
    for (i = 0; i < 6; i = i + 1) begin
      wr(5'h06 + i, 16'h0100);
      wr(5'h0C + i, 16'h7F00);
    end
    wr(5'h12, 16'h003F);
    wr(5'h13, 16'h3FFF);
    // exact limits and one step past each first, then random full-range or small signed values, ending in range
    for (i = 0; i < 16; i = i + 1) begin
      seed = lfsr(seed);
      fast_servo0 <= seed[3];
      fast_servo1 <= seed[9];
      d = seed[0] ? seed[14:0] : {{6{seed[8]}}, seed[8:0]};
      d = (i == 0) ? 15'h0100 : (i == 1) ? 15'h0101 : (i == 2) ? 15'h7F00 : (i == 3) ? 15'h7EFF : d;
      if (i == 15)
        d = 15'h0000;
      inst_e[1] = $signed(d) < $signed(15'h7F00);
      inst_e[7] = $signed(d) > $signed(15'h0100);
      lat_e = lat_e | inst_e;
      cv(1'b1, 1'b0, 3'h1, d);
      rd(5'h14, {2'b00, inst_e});
    end
    rd(5'h01, {1'b1, d});
    rd(5'h01, {1'b0, d});
    rd(5'h16, {15'h0000, |lat_e});
    rd(5'h16, {15'h0000, |lat_e});
    rd(5'h15, {2'b00, lat_e});
    rd(5'h15, 16'h0000);
    cv(1'b1, 1'b0, 3'h1, 15'h0200);
    wr(5'h17, 16'h003A);
    nop;
    #1 chk(alert_oe, 1'b1);
    nop;
    rd(5'h17, 16'h003A);
    rd(5'h15, 16'h0080);
    nop;
    #1 chk(alert_oe, 1'b0);
    cv(1'b1, 1'b0, 3'h1, 15'h0200);
    wr(5'h13, 16'h0000);
    rd(5'h15, 16'h0000);
    wr(5'h13, 16'h3FFF);
    wr(5'h07, 16'h3FFF);
    wr(5'h0D, 16'h4000);
    cv(1'b1, 1'b0, 3'h1, 15'h3FFF);
    rd(5'h14, 16'h0000);
    cv(1'b1, 1'b0, 3'h1, 15'h4000);
    rd(5'h14, 16'h0000);
    wr(5'h07, 16'h0100);
    wr(5'h0D, 16'h7F00);
    wr(5'h12, 16'h003D);
    cv(1'b1, 1'b0, 3'h1, 15'h0200);
    rd(5'h14, 16'h0000);
    rd(5'h01, 16'h8200);
    wr(5'h12, 16'h003F);
    wr(5'h17, 16'h0045);
    nop;
    #1 chk(gpin0_oe, 1'b0);
    chk(gpin1_oe, 1'b1);
    cv(1'b1, 1'b0, 3'h1, 15'h0200);
    #1 chk(gpin0_oe, 1'b1);
    trim_code0 <= 8'h00;
    cv(1'b0, 1'b1, 3'h0, 15'h0000);
    rd(5'h14, 16'h1080);
    #1 chk(gpin1_oe, 1'b0);
    trim_code0 <= 8'h80;
    trim_code1 <= 8'hFF;
    cv(1'b0, 1'b1, 3'h0, 15'h0000);
    rd(5'h14, 16'h2080);
    rd(5'h17, 16'h0165);
    wr(5'h17, 16'h006E);
    ext_low1 <= 1'b1;
    nop;
    #1 chk(gpin0_oe, 1'b1);
    chk(gpin1_oe, 1'b0);
    repeat (2) nop;
    rd(5'h17, 16'h014E);
    ext_low1 <= 1'b0;
    wr(5'h17, 16'h00CA);
    nop;
    #1 chk(conv_run, 1'b0);
    wr(5'h00, 16'h0200);
    cv(1'b1, 1'b0, 3'h0, 15'h0000);
    rd(5'h00, 16'h8200);
    rd(5'h14, 16'h20C0);
    repeat (2) nop;
    // second reset with the strap high: both pins must come up pulling low
    strap <= 1'b1;
    reset_n <= 1'b0;
    repeat (2) nop;
    reset_n <= 1'b1;
    repeat (3) nop;
    #1 chk(gpin0_oe, 1'b1);
    chk(gpin1_oe, 1'b1);
    rd(5'h17, 16'h014A);
    repeat (2) nop;
    results;
  end
endmodule
